// [common/adcsc_pkg.sv]
package adcsc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] RESULT_HIGH_ADDR = 16'hFFC4;
	localparam logic [15:0] RESULT_LOW_ADDR = 16'hFFC5;
	localparam logic [15:0] MODE_ADDR = 16'hFFC6;
	localparam logic [15:0] START_ADDR = 16'hFFC7;
	localparam logic [15:0] CLOCK_STOP_ONE_ADDR = 16'hFFFA;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int MODE_SPEED_BIT = 7;
	localparam int MODE_SPARE_BIT = 6;
	localparam int START_FLAG_BIT = 7;
	localparam int STANDBY_BIT = 4;
	localparam logic [7:0] MODE_RESET = 8'h30;
	localparam logic [7:0] START_RESET = 8'h7F;
	localparam logic [7:0] CLOCK_STOP_RESET = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ = 8'hFF;
	localparam logic [1:0] CHAN_VALID_TOP = 2'h1;

	// ----------------------------------------------------------------
	// Conversion timing in system clocks
	// ----------------------------------------------------------------
	localparam int RESULT_BITS = 10;
	localparam int SLOW_PERIOD = 62;
	localparam int FAST_PERIOD = 31;
	localparam int SLOW_STEP = SLOW_PERIOD / RESULT_BITS;
	localparam int FAST_STEP = FAST_PERIOD / RESULT_BITS;
	localparam int SLOW_SAMPLE = SLOW_PERIOD - SLOW_STEP * RESULT_BITS;
	localparam int FAST_SAMPLE = FAST_PERIOD - FAST_STEP * RESULT_BITS;

	typedef enum logic [1:0] {
		ADCSC_IDLE = 2'b00,
		ADCSC_SAMPLE = 2'b01,
		ADCSC_BITS = 2'b10
	} adcsc_state_t;
endpackage

// [verilog/adcsc_sar.sv]
`timescale 1ns/1ps
module adcsc_sar #(
	parameter int WIDTH = 10
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic load,
	input wire logic decide,
	input wire logic comp_in,
	output logic [WIDTH-1:0] code_q,
	output logic [WIDTH-1:0] resolved,
	output logic last_bit
);
	logic [WIDTH-1:0] ptr_q;
	localparam logic [WIDTH-1:0] TOP = {1'b1, {(WIDTH-1){1'b0}}};

	// Bit under trial is kept when the comparator says input is above it
	assign resolved = comp_in ? code_q : (code_q & ~ptr_q);
	assign last_bit = ptr_q[0];

	// Trial code walks from the most significant bit down
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			code_q <= '0;
			ptr_q <= '0;
		end else if (load) begin
			code_q <= TOP;
			ptr_q <= TOP;
		end else if (decide) begin
			code_q <= resolved | (ptr_q >> 1);
			ptr_q <= ptr_q >> 1;
		end
	end
endmodule

// [verilog/adcsc_top.sv]
`timescale 1ns/1ps
// Contract
// [RULE1] Four selectable inputs, ten-bit result
// [RULE2] Result bits 9..2 high, 1..0 low top
// [RULE3] Each finished conversion raises a request
// [RULE4] Result bytes readable always, undefined mid-conversion
// [RULE5] Result held until next conversion begins
// [RULE6] Reset never clears result bytes
// [RULE7] Mode register resets to 0x30
// [RULE8] Speed bit: 62 clocks at 0, 31 at 1
// [RULE9] Software keeps conversion at least 12.4 us
// [RULE10] Mode bit 6 plain storage, leave alone
// [RULE11] Mode bits 5,4 read one, ignore writes
// [RULE12] Channel code 01xx picks input, else none
// [RULE13] Change channel only while flag is zero
// [RULE14] Standby stops converter, keeps registers
// [RULE15] Write one starts; completion stores, clears flag
// [RULE16] Write zero stops; flag reads busy state
// [RULE17] Completion sets request; enable gates interrupt
// [RULE18] Standby bit 4: zero standby, one run
// [RULE19] Ten steps, MSB first, within period
module adcsc_top
	import adcsc_pkg::*;
#(
	parameter int WIDTH = RESULT_BITS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic comparator_in,
	output logic [WIDTH-1:0] ladder_code,
	output logic [3:0] channel_enable,
	output logic sample_hold,
	input wire logic conversion_done_enable,
	input wire logic conversion_done_clear,
	output logic conversion_done_request,
	output logic irq_req,
	output logic standby_active
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	adcsc_state_t state_q;
	logic speed_q;
	logic spare_q;
	logic [3:0] chan_q;
	logic flag_q;
	logic run_q;
	logic [5:0] cnt_q;
	logic [7:0] res_high_q;
	logic [1:0] res_low_q;
	logic [7:0] rdata_q;
	logic [3:0] chan_en_q;
	logic sample_q;
	logic req_q;
	logic irq_q;
	logic standby_q;
	logic standby_out_q;
	logic [WIDTH-1:0] sar_code;
	logic [WIDTH-1:0] sar_resolved;
	logic sar_last;
	logic wr_mode;
	logic wr_start;
	logic wr_stop;
	logic sar_load;
	logic sar_decide;
	logic finish;
	logic [5:0] step_len;
	logic [5:0] sample_len;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Mode and start writes are dropped in standby so registers hold
	assign wr_mode = bus_wr && run_q && (bus_addr == MODE_ADDR);
	assign wr_start = bus_wr && run_q && (bus_addr == START_ADDR)
		&& bus_wdata[START_FLAG_BIT];
	assign wr_stop = bus_wr && run_q && (bus_addr == START_ADDR)
		&& !bus_wdata[START_FLAG_BIT];

	// [RULE8] period split by speed
	assign step_len = speed_q ? 6'(FAST_STEP) : 6'(SLOW_STEP);
	assign sample_len = speed_q ? 6'(FAST_SAMPLE) : 6'(SLOW_SAMPLE);

	// Sequencer strobes, frozen while in standby
	assign sar_load = wr_start;
	assign sar_decide = run_q && (state_q == ADCSC_BITS) && (cnt_q == 6'h01);
	assign finish = sar_decide && sar_last;

	// ----------------------------------------------------------------
	// Standby control
	// ----------------------------------------------------------------
	// [RULE18] standby bit decode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			standby_q <= CLOCK_STOP_RESET[STANDBY_BIT];
		end else if (bus_wr && bus_addr == CLOCK_STOP_ONE_ADDR) begin
			standby_q <= bus_wdata[STANDBY_BIT];
		end
	end

	// [RULE14] standby freezes the converter
	// Status pin has its own flop so it is not an inverter off run_q
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			run_q <= CLOCK_STOP_RESET[STANDBY_BIT];
			standby_out_q <= !CLOCK_STOP_RESET[STANDBY_BIT];
		end else begin
			run_q <= standby_q;
			standby_out_q <= !standby_q;
		end
	end

	// ----------------------------------------------------------------
	// Mode register
	// ----------------------------------------------------------------
	// [RULE7] reset to documented mode value
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			speed_q <= MODE_RESET[MODE_SPEED_BIT];
			spare_q <= MODE_RESET[MODE_SPARE_BIT];
			chan_q <= MODE_RESET[3:0];
		end else if (wr_mode) begin
			// [RULE10] spare bit stored as written
			speed_q <= bus_wdata[MODE_SPEED_BIT];
			spare_q <= bus_wdata[MODE_SPARE_BIT];
			chan_q <= bus_wdata[3:0];
		end
	end

	// [RULE12] only 01xx enables an input; none and prohibited codes drive none
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			chan_en_q <= 4'h0;
		end else if (chan_q[3:2] == CHAN_VALID_TOP) begin
			// [RULE1] one of four inputs
			chan_en_q <= 4'h1 << chan_q[1:0];
		end else begin
			chan_en_q <= 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	// [RULE19] sample window then ten equal bit steps
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= ADCSC_IDLE;
			cnt_q <= 6'h00;
		end else if (wr_start) begin
			state_q <= ADCSC_SAMPLE;
			cnt_q <= sample_len;
		end else if (wr_stop) begin
			// [RULE16] stop abandons the conversion
			state_q <= ADCSC_IDLE;
			cnt_q <= 6'h00;
		end else if (run_q) begin
			case (state_q)
				ADCSC_IDLE: begin
					cnt_q <= 6'h00;
				end
				ADCSC_SAMPLE: begin
					if (cnt_q == 6'h01) begin
						state_q <= ADCSC_BITS;
						cnt_q <= step_len;
					end else begin
						cnt_q <= cnt_q - 6'h01;
					end
				end
				ADCSC_BITS: begin
					if (finish) begin
						state_q <= ADCSC_IDLE;
						cnt_q <= 6'h00;
					end else if (cnt_q == 6'h01) begin
						cnt_q <= step_len;
					end else begin
						cnt_q <= cnt_q - 6'h01;
					end
				end
				default: begin
					state_q <= ADCSC_IDLE;
					cnt_q <= 6'h00;
				end
			endcase
		end
	end

	// Sample-and-hold gate follows the sample window
	// [RULE14] gate drops in standby, else a frozen window would hold it open
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sample_q <= 1'b0;
		end else begin
			sample_q <= wr_start || (run_q && state_q == ADCSC_SAMPLE && cnt_q != 6'h01);
		end
	end

	// [RULE15] start sets flag, completion clears it; a new start wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flag_q <= START_RESET[START_FLAG_BIT];
		end else if (wr_start) begin
			flag_q <= 1'b1;
		end else if (wr_stop || finish) begin
			flag_q <= 1'b0;
		end
	end

	adcsc_sar #(
		.WIDTH(WIDTH)
	) u_sar (
		.clock(clock),
		.rst_n(rst_n),
		.load(sar_load),
		.decide(sar_decide),
		.comp_in(comparator_in),
		.code_q(sar_code),
		.resolved(sar_resolved),
		.last_bit(sar_last)
	);

	// ----------------------------------------------------------------
	// Result bytes
	// ----------------------------------------------------------------
	// [RULE6] no reset term: contents survive reset
	// [RULE5] written only at completion, held otherwise
	always_ff @(posedge clock) begin
		if (finish) begin
			// [RULE2] split ten bits over two bytes
			res_high_q <= sar_resolved[9:2];
			res_low_q <= sar_resolved[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Completion request
	// ----------------------------------------------------------------
	// [RULE3] request on every completion; set beats clear
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			req_q <= 1'b0;
		end else if (finish) begin
			req_q <= 1'b1;
		end else if (conversion_done_clear) begin
			req_q <= 1'b0;
		end
	end

	// [RULE17] interrupt gated by enable
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (req_q || finish) && conversion_done_enable;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// [RULE4] result bytes readable at any time
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_q <= UNMAPPED_READ;
		end else if (bus_rd) begin
			case (bus_addr)
				RESULT_HIGH_ADDR: rdata_q <= res_high_q;
				RESULT_LOW_ADDR: rdata_q <= {res_low_q, 6'h00};
				// [RULE11] bits 5 and 4 read as one
				MODE_ADDR: rdata_q <= {speed_q, spare_q, 2'h3, chan_q};
				START_ADDR: rdata_q <= {flag_q, START_RESET[6:0]};
				CLOCK_STOP_ONE_ADDR: begin
					rdata_q <= {CLOCK_STOP_RESET[7:5], standby_q, CLOCK_STOP_RESET[3:0]};
				end
				default: rdata_q <= UNMAPPED_READ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_rdata = rdata_q;
	assign ladder_code = sar_code;
	assign channel_enable = chan_en_q;
	assign sample_hold = sample_q;
	assign conversion_done_request = req_q;
	assign irq_req = irq_q;
	assign standby_active = standby_out_q;
endmodule

// [tb/adcsc_chk.sv]
`timescale 1ns/1ps
module adcsc_chk
	import adcsc_pkg::*;
#(
	parameter int WIDTH = 10
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic [WIDTH-1:0] ladder_code,
	input wire logic [3:0] channel_enable,
	input wire logic sample_hold,
	input wire logic conversion_done_enable,
	input wire logic conversion_done_request,
	input wire logic irq_req,
	input wire logic standby_active,
	input wire logic [7:0] bus_wdata
);
	// ----------------
	// Port properties
	// ----------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_irq; conversion_done_request && conversion_done_enable |=> irq_req; endproperty
	property p_irq_off; !conversion_done_enable |=> !irq_req; endproperty
	property p_chan; $onehot0(channel_enable); endproperty
	property p_samp; sample_hold ##1 sample_hold |=> !sample_hold; endproperty
	property p_msb; $rose(sample_hold) |-> ladder_code == {1'b1, {(WIDTH-1){1'b0}}}; endproperty
	property p_low; bus_rd && bus_addr == RESULT_LOW_ADDR |=> bus_rdata[5:0] == 6'h00; endproperty
	property p_mode; bus_rd && bus_addr == MODE_ADDR |=> bus_rdata[5:4] == 2'h3; endproperty
	property p_stby;
		bus_wr && bus_addr == CLOCK_STOP_ONE_ADDR && !bus_wdata[STANDBY_BIT]
			|-> ##[1:2] standby_active;
	endproperty
	property p_halt; standby_active [*2] |-> $stable(ladder_code) && !sample_hold; endproperty
	a_irq: assert property (p_irq) else $error("irq not raised");
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
	a_chan: assert property (p_chan) else $error("two inputs enabled");
	a_samp: assert property (p_samp) else $error("sample window too long");
	a_msb: assert property (p_msb) else $error("first trial not msb");
	a_low: assert property (p_low) else $error("low byte spare bits set");
	a_mode: assert property (p_mode) else $error("mode bits 5 4 not one");
	a_stby: assert property (p_stby) else $error("standby not entered");
	a_halt: assert property (p_halt) else $error("converter runs in standby");
	c_conv: cover property ($rose(sample_hold));
	c_irq: cover property ($rose(irq_req));
	c_stby: cover property ($rose(standby_active));
endmodule

// [tb/adcsc_front.sv]
`timescale 1ns/1ps
module adcsc_front (
	input wire logic [3:0] channel_enable,
	input wire logic [9:0] ladder_code,
	input wire logic [39:0] levels,
	output logic comparator_in
);
	// ----------------
	// Comparator
	// ----------------
	// trial versus input
	always_comb begin
		comparator_in = 1'b0; // Unselected inputs look like ground
		for (int i = 0; i < 4; i++) begin
			if (channel_enable[i]) comparator_in = levels[i*10 +: 10] >= ladder_code;
		end
	end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import adcsc_pkg::*;
	logic clock = 0;
	logic rst_n = 0;
	logic [15:0] bus_addr = 16'h0000;
	logic bus_wr = 0;
	logic bus_rd = 0;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] bus_rdata;
	logic comparator_in;
	logic [9:0] ladder_code;
	logic [3:0] channel_enable;
	logic sample_hold;
	logic conversion_done_enable = 0;
	logic conversion_done_clear = 0;
	logic conversion_done_request;
	logic irq_req;
	logic standby_active;
	logic [39:0] levels = 40'h0;
	logic [9:0] last_r;
	logic [7:0] exp_q[$];
	logic rd_seen = 0;
	logic [3:0] codes [6] = '{4'h0, 4'h8, 4'h4, 4'h5, 4'h6, 4'h7};
	int fail_count = 0;
	int num_checks = 0;

	always #4 clock = ~clock;
	adcsc_top i_adcsc_top (.*);
	adcsc_front i_adcsc_front (.*);

	// ----------------
	// Shared tasks
	// ----------------
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Idle cycle after each strobe so it never toggles twice in one step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1;
		@(negedge clock);
		bus_wr = 0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus_addr = a;
		bus_rd = 1;
		exp_q.push_back(e);
		@(negedge clock);
		bus_rd = 0;
		@(negedge clock);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// One conversion, with the flag sampled on both sides of the finish edge
	// limitation: this clock is too fast for the analog minimum
	task automatic conv(input logic [3:0] ch, input logic s);
		int per;
		per = s ? FAST_PERIOD : SLOW_PERIOD;
		levels = 40'({$urandom, $urandom});
		conversion_done_enable = 1'($urandom);
		last_r = (ch[3:2] == 2'h1) ? levels[ch[1:0]*10 +: 10] : 10'h000;
		wr(MODE_ADDR, {s, 3'h3, ch});
		rd(MODE_ADDR, {s, 3'h3, ch});
		wr(START_ADDR, 8'h80);
		check(channel_enable, (ch[3:2] == 2'h1) ? 4'h1 << ch[1:0] : 4'h0);
		repeat (per - 2) @(negedge clock);
		bus_addr = START_ADDR;
		bus_rd = 1;
		exp_q.push_back(8'hFF);
		exp_q.push_back(8'h7F);
		repeat (2) @(negedge clock);
		bus_rd = 0;
		@(negedge clock);
		check(conversion_done_request, 1'b1);
		check(irq_req, conversion_done_enable);
		rd(RESULT_HIGH_ADDR, last_r[9:2]);
		rd(RESULT_LOW_ADDR, {last_r[1:0], 6'h00});
		conversion_done_clear = 1;
		@(negedge clock);
		conversion_done_clear = 0;
	endtask

	// Read results land one edge after the strobe
	always @(posedge clock) rd_seen <= bus_rd;
	always @(negedge clock) begin
		if (rd_seen) check(bus_rdata, exp_q.pop_front());
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		tally_and_finish;
	end

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		void'($urandom(99898));
		repeat (3) @(negedge clock);
		rst_n = 1;
		@(negedge clock);
		rd(MODE_ADDR, 8'h30);
		rd(START_ADDR, 8'h7F);
		rd(CLOCK_STOP_ONE_ADDR, 8'hFF);
		rd(16'hFFC8, 8'hFF);
		wr(MODE_ADDR, 8'hFF);
		rd(MODE_ADDR, 8'hFF);
		wr(MODE_ADDR, 8'h00);
		rd(MODE_ADDR, 8'h30);
		$display("register reset test done");
		for (int i = 0; i < 6; i++) conv(codes[i], i[0]);
		$display("conversion test done");
		wr(START_ADDR, 8'h80);
		repeat (10) @(negedge clock);
		wr(START_ADDR, 8'h00);
		repeat (70) @(negedge clock);
		rd(START_ADDR, 8'h7F);
		rd(RESULT_HIGH_ADDR, last_r[9:2]);
		check(conversion_done_request, 1'b0);
		$display("abort test done");
		wr(CLOCK_STOP_ONE_ADDR, 8'hEF);
		rd(CLOCK_STOP_ONE_ADDR, 8'hEF);
		check(standby_active, 1'b1);
		wr(START_ADDR, 8'h80);
		wr(MODE_ADDR, 8'h00);
		rd(START_ADDR, 8'h7F);
		rd(MODE_ADDR, 8'hB7);
		check(sample_hold, 1'b0);
		wr(CLOCK_STOP_ONE_ADDR, 8'hFF);
		check(standby_active, 1'b0);
		$display("standby test done");
		rst_n = 0;
		repeat (2) @(negedge clock);
		rst_n = 1;
		@(negedge clock);
		rd(RESULT_HIGH_ADDR, last_r[9:2]);
		rd(MODE_ADDR, 8'h30);
		$display("second reset test done");
		tally_and_finish;
	end
endmodule

bind adcsc_top adcsc_chk #(.WIDTH(WIDTH)) i_adcsc_chk (.*);
